// ==== core/adc_gpio_fault_hold_control.sv ====
// pin configuration, hold input, fault pin and external mux select
// assumes register requests and all pins synchronous to i_mclk
//
// Function
// (RULE1) register at 0x06 resets to 0x0800, hold input enabled only
// (RULE2) host writes zero to bit 15; device reads it as zero
// (RULE3) bit 14 turns the bridge power-down switch on to sink current
// (RULE4) bit 13 enables output pins two and three as driven outputs
// (RULE5) bit 12 drives pins 0, 1 and 2 as mux select with sequencing
// (RULE6) host reselects analog input pair after every eight sequenced channels
// (RULE7) hold enabled, normal mode: low pin keeps modulator and filter reset
// (RULE8) per-channel mode: low pin at switch delays next conversion
// (RULE9) fault mode 01: pin is input, inverted into fault flag, read uninverted as level
// (RULE10) fault mode 10: ORed errors inverted, driven open-drain on pin
// (RULE11) fault mode 11: general output with active pull-up at level bit
// (RULE12) level bit drives output mode, reads sampled pin in input mode
// (RULE13) bits 7 and 6 set levels of output pins three and two
// (RULE14) bit 5 makes bidirectional pin one an input
`timescale 1ns/1ns
module adc_gpio_fault_hold_control
(
	// clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_b,
	// register access
	input  wire pin_cfg_pkg::reg_req_t     i_req,
	output logic                           o_rd_valid,
	output logic [15:0]                    o_rd_data,
	// core interaction
	input  wire logic                      i_per_channel_hold_mode,
	input  wire logic                      i_multi_channel,
	input  wire logic                      i_chan_switch_due,
	input  wire logic [2:0]                i_chan_index,
	input  wire logic                      i_status_errors,
	output logic                           o_filter_reset,
	output logic                           o_conv_stall,
	output logic                           o_fault_flag,
	output logic                           o_pin1_input_en,
	// pins
	input  wire logic                      i_hold_pin,
	input  wire logic                      i_fault_pin,
	output logic                           o_fault_pin,
	output logic                           o_fault_pin_oe,
	output logic                           o_bridge_switch_on,
	output logic                           o_bidir_pin0,
	output logic                           o_bidir_pin0_oe,
	output logic                           o_bidir_pin1,
	output logic                           o_bidir_pin1_oe,
	output logic                           o_out_pin2,
	output logic                           o_out_pin2_oe,
	output logic                           o_out_pin3,
	output logic                           o_out_pin3_oe
);
	logic [15:0]          word;
	logic                 fault_sample;
	logic                 stall;
	pin_cfg_pkg::cfg_t    cfg;
	logic [2:0]           mux_sel;

	// read view: masked word with the level bit swapped in
	function automatic logic [15:0] read_view
	(
		input logic [15:0] stored,
		input logic        level
	);
		logic [15:0] view;
		view = stored & pin_cfg_pkg::PIN_CFG_RDMASK;
		view[pin_cfg_pkg::BIT_FLVL] = level;
		return view;
	endfunction : read_view

	// one select line: channel bit while mux control is on
	function automatic logic mux_line
	(
		input logic en,
		input logic sel,
		input logic idle
	);
		return en ? sel : idle;
	endfunction : mux_line

	wire hit      = i_req.addr == pin_cfg_pkg::PIN_CFG_ADDR;
	wire we       = i_req.wr && hit;

	pin_cfg_reg u_reg
	(
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_we    (we),
		.i_wdata (i_req.wdata),
		.o_word  (word)
	);

	assign cfg.bridge_power_switch_en = word[pin_cfg_pkg::BIT_BRIDGE_POWER_SWITCH_EN];
	assign cfg.upper_outputs_en       = word[pin_cfg_pkg::BIT_UPOUT];
	assign cfg.ext_mux_ctrl_en        = word[pin_cfg_pkg::BIT_MUX];
	assign cfg.hold_en                = word[pin_cfg_pkg::BIT_HOLD];
	assign cfg.fault_mode             = pin_cfg_pkg::fault_mode_t'(
		word[pin_cfg_pkg::BIT_FMODE_H:pin_cfg_pkg::BIT_FMODE_L]);
	assign cfg.fault_pin_level        = word[pin_cfg_pkg::BIT_FLVL];
	assign cfg.out3_level             = word[pin_cfg_pkg::BIT_OUT3];
	assign cfg.out2_level             = word[pin_cfg_pkg::BIT_OUT2];
	assign cfg.pin1_input_en          = word[pin_cfg_pkg::BIT_IN1];

	wire fault_in  = cfg.fault_mode == pin_cfg_pkg::FAULT_IN;
	wire fault_od  = cfg.fault_mode == pin_cfg_pkg::FAULT_OD;
	wire fault_gpo = cfg.fault_mode == pin_cfg_pkg::FAULT_GPO;

	// read data: level bit replaced by sampled pin in input mode
	wire        rd_level     = fault_in ? fault_sample
		: cfg.fault_pin_level; // RULE12
	wire [15:0] rd_word      = hit
		? read_view(word, rd_level)
		: 16'h0000;
	wire [15:0] next_rd_data = i_req.rd ? rd_word : 16'h0000; // RULE2

	// hold behaviour
	wire alt_hold     = i_per_channel_hold_mode && i_multi_channel;
	wire hold_low     = cfg.hold_en && !i_hold_pin;
	wire next_freset  = hold_low && !alt_hold; // RULE7
	wire next_stall   = cfg.hold_en && alt_hold
		&& ((i_chan_switch_due && !i_hold_pin)
		|| (stall && !i_hold_pin)); // RULE8

	// fault pin drive
	wire next_fault_oe  = (fault_od && i_status_errors) || fault_gpo;
	wire next_fault_out = fault_gpo ? cfg.fault_pin_level
		: 1'b0; // RULE11
	wire next_fault_flag = fault_in && !fault_sample; // RULE9

	// mux select follows channel sequence
	wire next_mux_en = cfg.ext_mux_ctrl_en; // RULE5
	wire next_pin0   = mux_line(next_mux_en,
		mux_sel[pin_cfg_pkg::MUX_BIT_PIN0], 1'b0); // RULE5
	wire next_pin1   = mux_line(next_mux_en,
		mux_sel[pin_cfg_pkg::MUX_BIT_PIN1], 1'b0); // RULE5
	wire next_pin2   = mux_line(next_mux_en,
		mux_sel[pin_cfg_pkg::MUX_BIT_PIN2], cfg.out2_level); // RULE5 RULE13

	// mux control takes pin one from its input role
	wire next_pin1_in = cfg.pin1_input_en && !next_mux_en; // RULE14

	// switch and upper outputs
	wire next_switch  = cfg.bridge_power_switch_en; // RULE3
	wire next_pin2_oe = next_mux_en || cfg.upper_outputs_en; // RULE4
	wire next_pin3    = cfg.out3_level; // RULE13
	wire next_pin3_oe = cfg.upper_outputs_en; // RULE4

	// register read port
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_rd_valid <= 1'b0;
		else
			o_rd_valid <= i_req.rd;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_rd_data <= 16'h0000;
		else
			o_rd_data <= next_rd_data; // RULE12
	end

	// sample starts at the pulled-up idle level: no false fault after reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			fault_sample <= 1'b1;
		else
			fault_sample <= i_fault_pin; // RULE9
	end

	// stall and mux select state
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			stall <= 1'b0;
		else
			stall <= next_stall; // RULE8
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			mux_sel <= 3'h0;
		else
			mux_sel <= i_chan_index; // RULE5
	end

	// core-facing controls
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_filter_reset <= 1'b0;
		else
			o_filter_reset <= next_freset; // RULE7
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_conv_stall <= 1'b0;
		else
			o_conv_stall <= next_stall; // RULE8
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_fault_flag <= 1'b0;
		else
			o_fault_flag <= next_fault_flag; // RULE9
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_pin1_input_en <= 1'b0;
		else
			o_pin1_input_en <= next_pin1_in; // RULE14
	end

	// fault pin drive
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_fault_pin <= 1'b0;
		else
			o_fault_pin <= next_fault_out; // RULE10
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_fault_pin_oe <= 1'b0;
		else
			o_fault_pin_oe <= next_fault_oe; // RULE10
	end

	// switch and general-purpose pins
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_bridge_switch_on <= 1'b0;
		else
			o_bridge_switch_on <= next_switch; // RULE3
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_bidir_pin0 <= 1'b0;
		else
			o_bidir_pin0 <= next_pin0; // RULE5
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_bidir_pin0_oe <= 1'b0;
		else
			o_bidir_pin0_oe <= next_mux_en; // RULE5
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_bidir_pin1 <= 1'b0;
		else
			o_bidir_pin1 <= next_pin1; // RULE5
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_bidir_pin1_oe <= 1'b0;
		else
			o_bidir_pin1_oe <= next_mux_en; // RULE5
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_out_pin2 <= 1'b0;
		else
			o_out_pin2 <= next_pin2; // RULE13
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_out_pin2_oe <= 1'b0;
		else
			o_out_pin2_oe <= next_pin2_oe; // RULE4
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_out_pin3 <= 1'b0;
		else
			o_out_pin3 <= next_pin3; // RULE13
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_out_pin3_oe <= 1'b0;
		else
			o_out_pin3_oe <= next_pin3_oe; // RULE4
	end
endmodule : adc_gpio_fault_hold_control

// ==== core/pin_cfg_pkg.sv ====
// pin configuration register: offsets, field positions, reset value, types
// assumes one register word of 16 bits behind a simple write/read port
package pin_cfg_pkg;
	localparam logic [7:0]  PIN_CFG_ADDR   = 8'h06;
	localparam logic [15:0] PIN_CFG_RESET  = 16'h0800;
	// bits that hold storage and read back (15 reserved, 7 and 6 write-only)
	localparam logic [15:0] PIN_CFG_RDMASK = 16'h7f3f;
	// bits that accept a write (15 reserved)
	localparam logic [15:0] PIN_CFG_WRMASK = 16'h7fff;
	localparam int BIT_BRIDGE_POWER_SWITCH_EN    = 14;
	localparam int BIT_UPOUT   = 13;
	localparam int BIT_MUX     = 12;
	localparam int BIT_HOLD    = 11;
	localparam int BIT_FMODE_H = 10;
	localparam int BIT_FMODE_L = 9;
	localparam int BIT_FLVL    = 8;
	localparam int BIT_OUT3    = 7;
	localparam int BIT_OUT2    = 6;
	localparam int BIT_IN1     = 5;
	localparam int MUX_WIDTH   = 3;
	localparam int MUX_BIT_PIN0 = 0;
	localparam int MUX_BIT_PIN1 = 1;
	localparam int MUX_BIT_PIN2 = 2;

	typedef enum logic [1:0]
	{
		FAULT_OFF,
		FAULT_IN,
		FAULT_OD,
		FAULT_GPO
	} fault_mode_t;

	typedef struct packed
	{
		logic        bridge_power_switch_en;
		logic        upper_outputs_en;
		logic        ext_mux_ctrl_en;
		logic        hold_en;
		fault_mode_t fault_mode;
		logic        fault_pin_level;
		logic        out3_level;
		logic        out2_level;
		logic        pin1_input_en;
	} cfg_t;

	// register bus request
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;
endpackage : pin_cfg_pkg

// ==== core/pin_cfg_reg.sv ====
// storage word of the pin configuration register
// assumes writes come one per cycle from the serial register decoder
`timescale 1ns/1ns
module pin_cfg_reg
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	// write port
	input  wire logic        i_we,
	input  wire logic [15:0] i_wdata,
	// stored word
	output logic      [15:0] o_word
);
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_word <= pin_cfg_pkg::PIN_CFG_RESET; // RULE1
		else if (i_we)
			o_word <= i_wdata & pin_cfg_pkg::PIN_CFG_WRMASK; // RULE2
	end
endmodule : pin_cfg_reg

// ==== dv/adc_gpio_fault_hold_control_props.sv ====
// assertions on the pin configuration block ports
// assumes one clock and a sync active-low reset
`timescale 1ns/1ns
module adc_gpio_fault_hold_control_props
(
	// clock, reset and inputs
	input wire logic		i_mclk,
	input wire logic		i_rst_b,
	input wire pin_cfg_pkg::reg_req_t	i_req,
	input wire logic		i_hold_pin,
	input wire logic		i_fault_pin,
	input wire logic		i_chan_switch_due,
	input wire logic [2:0]	i_chan_index,
	// outputs
	input wire logic		o_rd_valid,
	input wire logic [15:0]	o_rd_data,
	input wire logic		o_out_pin2_oe,
	input wire logic		o_out_pin3_oe,
	input wire logic		o_fault_flag,
	input wire logic		o_filter_reset,
	input wire logic		o_conv_stall,
	input wire logic		o_bidir_pin0,
	input wire logic		o_bidir_pin0_oe,
	input wire logic		o_pin1_input_en,
	input wire logic		o_bidir_pin1_oe
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_rd_answer: assert property (i_req.rd |=> o_rd_valid)
		else $error("read not answered");
	a_rd_masked: assert property (
		o_rd_valid |-> (o_rd_data & 16'h80c0) == 16'h0000)
		else $error("reserved or write-only bit read high");
	a_upper_pair: assert property (o_out_pin3_oe |-> o_out_pin2_oe)
		else $error("pin 3 driven without pin 2");
	a_fault_inv: assert property (
		o_fault_flag |-> !$past(i_fault_pin, 2))
		else $error("fault flag without low pin");
	a_hold_reset: assert property (
		o_filter_reset |-> !$past(i_hold_pin))
		else $error("filter reset with hold pin high");
	a_stall_cause: assert property (
		$rose(o_conv_stall) |-> $past(i_chan_switch_due) && !$past(i_hold_pin))
		else $error("stall without due switch and low pin");
	a_mux_follow: assert property (
		o_bidir_pin0_oe |-> o_bidir_pin0 == $past(i_chan_index[0], 2))
		else $error("mux select does not follow channel");
	a_pin1_input: assert property (
		o_pin1_input_en |-> !o_bidir_pin1_oe)
		else $error("pin 1 driven while input");
endmodule : adc_gpio_fault_hold_control_props

bind adc_gpio_fault_hold_control adc_gpio_fault_hold_control_props
	adc_gpio_fault_hold_control_props_inst (.*);

// ==== dv/fault_line_model.sv ====
// shared fault line with pull-up and another open-drain party
// assumes oe high while the device drives the pin
`timescale 1ns/1ns
module fault_line_model
(
	// device drive and other party
	input  wire logic	i_pin,
	input  wire logic	i_oe,
	input  wire logic	i_other_low,
	// resolved level
	output logic		o_line
);
	// pulled up unless some party sinks it
	assign o_line = !(i_other_low || (i_oe && !i_pin));
endmodule : fault_line_model

// ==== dv/tb_adc_gpio_fault_hold_control.sv ====
// bench: register tasks and pin stimulus at the falling edge
// assumes pins settle one edge after a write is taken
`timescale 1ns/1ns
module tb_adc_gpio_fault_hold_control;
	pin_cfg_pkg::reg_req_t	i_req = '0;
	logic	i_mclk = 1'b0, i_rst_b = 1'b0, i_hold_pin = 1'b1;
	logic	i_per_channel_hold_mode = 1'b0, i_multi_channel = 1'b0;
	logic	i_chan_switch_due = 1'b0, i_status_errors = 1'b0, low = 1'b0;
	logic	[2:0] i_chan_index = 3'h0;
	logic	[15:0] o_rd_data;
	logic	i_fault_pin, o_rd_valid, o_filter_reset, o_conv_stall;
	logic	o_fault_flag, o_pin1_input_en, o_fault_pin, o_fault_pin_oe;
	logic	o_bridge_switch_on, o_bidir_pin0, o_bidir_pin0_oe, o_bidir_pin1;
	logic	o_bidir_pin1_oe, o_out_pin2, o_out_pin2_oe, o_out_pin3;
	logic	o_out_pin3_oe;
	int	errors = 0;
	int	checks = 0;
	adc_gpio_fault_hold_control adc_gpio_fault_hold_control_inst (.*);
	fault_line_model fault_line_model_inst (.i_pin(o_fault_pin),
		.i_oe(o_fault_pin_oe), .i_other_low(low), .o_line(i_fault_pin));
	initial forever #5 i_mclk = ~i_mclk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : tick
	task automatic wr(input logic [15:0] d);
		i_req = '{1'b1, 1'b0, 8'h06, d};
		tick(1);
		i_req = '0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_req = '{1'b0, 1'b1, a, 16'h0000};
		tick(1);
		i_req = '0;
		chk(o_rd_valid, 16'h0001);
		chk(o_rd_data, e);
	endtask : rd
	task automatic stop_test;
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial
	begin
		tick(8);
		i_rst_b = 1'b1;
		tick(1);
		rd(8'h06, 16'h0800);
		wr(16'h7fe0);
		rd(8'h06, 16'h7f20);
		chk({o_bridge_switch_on, o_fault_pin_oe, i_fault_pin}, 16'h0007);
		rd(8'h07, 16'h0000);
		wr(16'h6040);
		chk({o_bridge_switch_on, o_out_pin3_oe, o_out_pin2_oe, o_out_pin3,
			o_out_pin2}, 16'h001d);
		wr(16'h0080);
		chk({o_bridge_switch_on, o_out_pin3_oe, o_out_pin2_oe, o_out_pin3},
			16'h0001);
		wr(16'h1000);
		for (int k = 0; k < 8; k++)
		begin
			i_chan_index = k[2:0];
			tick(2);
			chk({o_out_pin2, o_bidir_pin1, o_bidir_pin0}, {13'h0, k[2:0]});
		end
		chk({o_out_pin2_oe, o_bidir_pin1_oe, o_bidir_pin0_oe}, 16'h0007);
		wr(16'h0020);
		chk({o_pin1_input_en, o_bidir_pin1_oe}, 16'h0002);
		low = 1'b1;
		wr(16'h0200);
		chk(o_fault_flag, 16'h0001);
		rd(8'h06, 16'h0200);
		low = 1'b0;
		tick(2);
		chk(o_fault_flag, 16'h0000);
		rd(8'h06, 16'h0300);
		wr(16'h0400);
		i_status_errors = 1'b1;
		tick(2);
		chk({o_fault_pin_oe, i_fault_pin}, 16'h0002);
		i_status_errors = 1'b0;
		tick(2);
		chk({o_fault_pin_oe, i_fault_pin}, 16'h0001);
		wr(16'h0800);
		i_hold_pin = 1'b0;
		tick(2);
		chk(o_filter_reset, 16'h0001);
		i_hold_pin = 1'b1;
		tick(2);
		chk(o_filter_reset, 16'h0000);
		{i_per_channel_hold_mode, i_multi_channel} = 2'b11;
		i_hold_pin = 1'b0;
		i_chan_switch_due = 1'b1;
		tick(1);
		i_chan_switch_due = 1'b0;
		tick(1);
		chk({o_filter_reset, o_conv_stall}, 16'h0001);
		i_hold_pin = 1'b1;
		tick(2);
		chk(o_conv_stall, 16'h0000);
		i_rst_b = 1'b0;
		tick(2);
		i_rst_b = 1'b1;
		tick(1);
		rd(8'h06, 16'h0800);
		stop_test();
	end
endmodule : tb_adc_gpio_fault_hold_control
